//--- core/bst_pkg.sv
// Shared constants and types for the bit-skip and table-read execution block
package bst_pkg;

  // Program and data memory geometry
  localparam int PM_AW     = 12;
  localparam int WORD_W    = 15;
  localparam int PTR_W     = 8;
  localparam int PAGE_W    = PM_AW - PTR_W;
  localparam int DM_AW     = 8;
  localparam int DM_DW     = 8;
  localparam int BIT_W     = 3;
  localparam int HIGH_W    = WORD_W - DM_DW;

  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;

  // Value of the tested bit that makes the skip happen
  localparam logic SKIP_LEVEL = 1'h0;

  // Operation codes presented with the start strobe
  typedef enum logic [1:0] {
    OP_SKIP_IF_BIT_CLEAR = 2'h0,
    OP_TABLE_READ_CURR   = 2'h1,
    OP_TABLE_READ_LAST   = 2'h2,
    OP_NONE              = 2'h3
  } bst_op_t;

  // Execution states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_BIT_WAIT = 5'h02,
    ST_DUMMY    = 5'h04,
    ST_PM_WAIT  = 5'h08,
    ST_UNUSED   = 5'h10
  } bst_state_t;

endpackage : bst_pkg

//--- core/bst_tbl_if.sv
// Carrier between the executor and the table address and word splitter
`timescale 1ns/1ps
interface bst_tbl_if;
  logic                           last_page;
  logic [bst_pkg::PTR_W-1:0]      ptr;
  logic [bst_pkg::PAGE_W-1:0]     page;
  logic [bst_pkg::WORD_W-1:0]     word;
  logic [bst_pkg::PM_AW-1:0]      pm_addr;
  logic [bst_pkg::DM_DW-1:0]      low_byte;
  logic [bst_pkg::HIGH_W-1:0]     high_part;

  modport exec (
    output last_page,
    output ptr,
    output page,
    output word,
    input  pm_addr,
    input  low_byte,
    input  high_part
  );

  modport tbl (
    input  last_page,
    input  ptr,
    input  page,
    input  word,
    output pm_addr,
    output low_byte,
    output high_part
  );
endinterface : bst_tbl_if

//--- core/bst_tbl_rd.sv
// Table-read address former and program word splitter
`timescale 1ns/1ps
module bst_tbl_rd (
  bst_tbl_if.tbl t
);

  // Page comes from the program counter or is forced to the last one
  always_comb begin
    if (t.last_page) begin
      t.pm_addr = {bst_pkg::LAST_PAGE, t.ptr};
    end else begin
      t.pm_addr = {t.page, t.ptr};
    end
  end

  assign t.low_byte  = t.word[bst_pkg::DM_DW-1:0];
  assign t.high_part = t.word[bst_pkg::WORD_W-1:bst_pkg::DM_DW];

endmodule : bst_tbl_rd

//--- core/bst_exec.sv
// Executor for the bit-test skip and the two table-read instructions
`timescale 1ns/1ps
module bst_exec #(
  parameter int PM_AW  = bst_pkg::PM_AW,
  parameter int WORD_W = bst_pkg::WORD_W
) (
  input  wire logic                           SYS_CLK,
  input  wire logic                           ARST_N,
  input  wire logic                           EXEC_START,
  input  wire logic [1:0]                     EXEC_OP,
  input  wire logic [bst_pkg::DM_AW-1:0]      EXEC_ADDR,
  input  wire logic [bst_pkg::BIT_W-1:0]      EXEC_BIT,
  input  wire logic [bst_pkg::PTR_W-1:0]      TABLE_POINTER,
  input  wire logic [bst_pkg::PAGE_W-1:0]     PC_PAGE,
  input  wire logic [bst_pkg::DM_DW-1:0]      DM_RDATA,
  input  wire logic [bst_pkg::WORD_W-1:0]     PM_RDATA,
  output logic                                DM_RD_EN,
  output logic                                DM_WR_EN,
  output logic [bst_pkg::DM_AW-1:0]           DM_ADDR,
  output logic [bst_pkg::DM_DW-1:0]           DM_WDATA,
  output logic                                PM_RD_EN,
  output logic [bst_pkg::PM_AW-1:0]           PM_ADDR,
  output logic [bst_pkg::HIGH_W-1:0]          TABLE_HIGH_BYTE,
  output logic                                SKIP_NEXT,
  output logic                                DUMMY_SLOT,
  output logic                                FLAG_WE,
  output logic                                BUSY,
  output logic                                EXEC_DONE
);

  // The datapath is laid out for the packaged geometry only
  if (PM_AW != bst_pkg::PM_AW || WORD_W != bst_pkg::WORD_W) begin : g_geom_chk
    $error("bst_exec: unsupported program memory geometry");
  end

  // Bit index must reach every bit of a data byte and no further
  if ((1 << bst_pkg::BIT_W) != bst_pkg::DM_DW) begin : g_bit_chk
    $error("bst_exec: bit index width does not match data width");
  end

  // Table-high register takes whatever the low byte leaves of a word
  if (bst_pkg::HIGH_W < 1 || bst_pkg::PAGE_W < 1) begin : g_split_chk
    $error("bst_exec: word or page split leaves no bits");
  end

  // The last page is the highest one the page field can name
  if (bst_pkg::LAST_PAGE != {bst_pkg::PAGE_W{1'h1}}) begin : g_page_chk
    $error("bst_exec: last page constant is not the final page");
  end

  bst_pkg::bst_state_t                 state;
  bst_pkg::bst_state_t                 next_state;
  bst_pkg::bst_op_t                    op;
  logic [bst_pkg::BIT_W-1:0]           bit_sel;
  logic [bst_pkg::DM_AW-1:0]           addr;
  logic                                start_ok;
  logic                                bit_skip;
  logic                                next_skip;
  logic                                next_dummy;
  logic                                next_busy;
  logic                                next_done;

  bst_tbl_if tif ();

  // Start only accepted when idle; requests while busy are dropped
  assign start_ok = EXEC_START && (state == bst_pkg::ST_IDLE) &&
                    (bst_pkg::bst_op_t'(EXEC_OP) != bst_pkg::OP_NONE);

  // Data memory answers in the same cycle as the read strobe
  assign bit_skip = (DM_RDATA[bit_sel] == bst_pkg::SKIP_LEVEL);

  assign tif.last_page = (bst_pkg::bst_op_t'(EXEC_OP) == bst_pkg::OP_TABLE_READ_LAST);
  assign tif.ptr       = TABLE_POINTER;
  assign tif.page      = PC_PAGE;
  assign tif.word      = PM_RDATA;

  bst_tbl_rd u_tbl (
    .t (tif.tbl)
  );

  // Latched instruction fields
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op      <= bst_pkg::OP_NONE;
      bit_sel <= '0;
      addr    <= '0;
    end else if (start_ok) begin
      op      <= bst_pkg::bst_op_t'(EXEC_OP);
      bit_sel <= EXEC_BIT;
      addr    <= EXEC_ADDR;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      bst_pkg::ST_IDLE: begin
        if (start_ok) begin
          if (bst_pkg::bst_op_t'(EXEC_OP) == bst_pkg::OP_SKIP_IF_BIT_CLEAR) begin
            next_state = bst_pkg::ST_BIT_WAIT;
          end else begin
            next_state = bst_pkg::ST_PM_WAIT;
          end
        end
      end
      bst_pkg::ST_BIT_WAIT: begin
        if (bit_skip) begin
          next_state = bst_pkg::ST_DUMMY;
        end else begin
          next_state = bst_pkg::ST_IDLE;
        end
      end
      bst_pkg::ST_DUMMY: begin
        // Slot stands in for the discarded instruction
        next_state = bst_pkg::ST_IDLE;
      end
      bst_pkg::ST_PM_WAIT: begin
        next_state = bst_pkg::ST_IDLE;
      end
      default: begin
        next_state = bst_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= bst_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data memory read for the bit test, write for the table reads
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DM_RD_EN <= 1'h0;
      DM_WR_EN <= 1'h0;
      DM_ADDR  <= '0;
      DM_WDATA <= '0;
    end else begin
      DM_RD_EN <= 1'h0;
      DM_WR_EN <= 1'h0;
      if (start_ok && bst_pkg::bst_op_t'(EXEC_OP) == bst_pkg::OP_SKIP_IF_BIT_CLEAR) begin
        DM_RD_EN <= 1'h1;
        DM_ADDR  <= EXEC_ADDR;
      end else if (state == bst_pkg::ST_PM_WAIT) begin
        // Write waits for the word; a write at take would store a stale word
        DM_WR_EN <= 1'h1;
        DM_ADDR  <= addr;
        DM_WDATA <= tif.low_byte;
      end
    end
  end

  // Program memory fetch, address formed by the splitter
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PM_RD_EN <= 1'h0;
      PM_ADDR  <= '0;
    end else begin
      PM_RD_EN <= 1'h0;
      if (start_ok && bst_pkg::bst_op_t'(EXEC_OP) != bst_pkg::OP_SKIP_IF_BIT_CLEAR) begin
        PM_RD_EN <= 1'h1;
        PM_ADDR  <= tif.pm_addr;
      end
    end
  end

  // Updated in the same cycle as the data memory write
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TABLE_HIGH_BYTE <= '0;
    end else if (state == bst_pkg::ST_PM_WAIT) begin
      TABLE_HIGH_BYTE <= tif.high_part;
    end
  end

  // Pipeline-facing pulses follow the state move of this cycle
  always_comb begin
    next_skip  = (state == bst_pkg::ST_BIT_WAIT) && bit_skip;
    next_dummy = (next_state == bst_pkg::ST_DUMMY);
    next_busy  = (next_state != bst_pkg::ST_IDLE);
    next_done  = (state != bst_pkg::ST_IDLE) && (next_state == bst_pkg::ST_IDLE);
  end

  // Skip signalling toward the fetch pipeline
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SKIP_NEXT  <= 1'h0;
      DUMMY_SLOT <= 1'h0;
    end else begin
      SKIP_NEXT  <= next_skip;
      DUMMY_SLOT <= next_dummy;
    end
  end

  // None of these instructions writes a flag; kept as a port so the core sees it
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLAG_WE <= 1'h0;
    end else begin
      FLAG_WE <= 1'h0;
    end
  end

  // Completion and occupancy
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUSY      <= 1'h0;
      EXEC_DONE <= 1'h0;
    end else begin
      BUSY      <= next_busy;
      EXEC_DONE <= next_done;
    end
  end

endmodule : bst_exec

//--- dv/bst_exec_asserts.sv
// Port-level checks for the executor
`timescale 1ns/1ps
module bst_exec_asserts (
  input logic        SYS_CLK,
  input logic        ARST_N,
  input logic        EXEC_START,
  input logic        DM_RD_EN,
  input logic        DM_WR_EN,
  input logic        PM_RD_EN,
  input logic        SKIP_NEXT,
  input logic        DUMMY_SLOT,
  input logic        FLAG_WE,
  input logic        BUSY,
  input logic        EXEC_DONE,
  input logic [1:0]  EXEC_OP,
  input logic [2:0]  EXEC_BIT,
  input logic [7:0]  EXEC_ADDR,
  input logic [7:0]  TABLE_POINTER,
  input logic [7:0]  DM_RDATA,
  input logic [7:0]  DM_ADDR,
  input logic [7:0]  DM_WDATA,
  input logic [3:0]  PC_PAGE,
  input logic [14:0] PM_RDATA,
  input logic [11:0] PM_ADDR,
  input logic [6:0]  TABLE_HIGH_BYTE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  logic [2:0]  bit_q;
  logic [7:0]  addr_q;
  logic [14:0] pm_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_q  <= 3'h0;
      addr_q <= 8'h00;
    end else if (EXEC_START && !BUSY && EXEC_OP != 2'h3) begin
      bit_q  <= EXEC_BIT;
      addr_q <= EXEC_ADDR;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    pm_q <= PM_RDATA;
  end
  sequence s_rd(logic lvl);
    DM_RD_EN && DM_RDATA[bit_q] == lvl;
  endsequence
  sequence s_take(logic [1:0] op);
    EXEC_START && !BUSY && EXEC_OP == op;
  endsequence
  property p_taken; s_rd(1'h0) |=> SKIP_NEXT ##1 EXEC_DONE && !SKIP_NEXT; endproperty
  property p_rd_addr; DM_RD_EN |-> DM_ADDR == addr_q && BUSY; endproperty
  property p_dummy; DUMMY_SLOT |-> SKIP_NEXT && BUSY && !EXEC_DONE ##1 EXEC_DONE && !BUSY; endproperty
  property p_not_taken; s_rd(1'h1) |=> !SKIP_NEXT && !DUMMY_SLOT && EXEC_DONE; endproperty
  property p_skip_flag; DM_RD_EN |-> !FLAG_WE [*3]; endproperty
  property p_curr; s_take(2'h1) |=> PM_RD_EN && PM_ADDR == {$past(PC_PAGE), $past(TABLE_POINTER)}; endproperty
  property p_low; PM_RD_EN |=> DM_WR_EN && EXEC_DONE && DM_ADDR == addr_q && DM_WDATA == pm_q[7:0]; endproperty
  property p_high; PM_RD_EN |=> TABLE_HIGH_BYTE == pm_q[14:8] ##1 $stable(TABLE_HIGH_BYTE); endproperty
  property p_tbl_flag; PM_RD_EN |-> !FLAG_WE ##1 !FLAG_WE; endproperty
  property p_last; s_take(2'h2) |=> PM_RD_EN && PM_ADDR == {bst_pkg::LAST_PAGE, $past(TABLE_POINTER)}; endproperty
  a_taken: assert property (p_taken) else $error("taken skip wrong");
  a_rd_addr: assert property (p_rd_addr) else $error("bit read address wrong");
  a_dummy: assert property (p_dummy) else $error("dummy slot wrong");
  a_not_taken: assert property (p_not_taken) else $error("untaken skip wrong");
  a_skip_flag: assert property (p_skip_flag) else $error("skip wrote flags");
  a_curr: assert property (p_curr) else $error("current page address wrong");
  a_low: assert property (p_low) else $error("low byte write wrong");
  a_high: assert property (p_high) else $error("table high byte wrong");
  a_tbl_flag: assert property (p_tbl_flag) else $error("table read wrote flags");
  a_last: assert property (p_last) else $error("last page address wrong");
endmodule : bst_exec_asserts

//--- dv/bst_mem_model.sv
// Data and program memory stand-in
`timescale 1ns/1ps
module bst_mem_model (
  input  logic        clk,
  input  logic        dm_rd_en,
  input  logic [7:0]  dm_addr,
  input  logic        pm_rd_en,
  input  logic [11:0] pm_addr,
  output logic [7:0]  dm_rdata,
  output logic [14:0] pm_rdata
);
  logic dm_hold, pm_hold;
  always_ff @(posedge clk) begin
    dm_hold <= dm_rd_en;
    pm_hold <= pm_rd_en;
  end
  // Inverted data outside the read window, so a sample more than one cycle after the strobe never matches
  assign dm_rdata = (dm_rd_en | dm_hold) ? (dm_addr ^ 8'hA5) : ~(dm_addr ^ 8'hA5);
  assign pm_rdata = (pm_rd_en | pm_hold) ? {pm_addr[2:0], pm_addr} : ~{pm_addr[2:0], pm_addr};
endmodule : bst_mem_model

//--- dv/tb_bst_exec.sv
// Self-checking bench for the executor
`timescale 1ns/1ps
module tb_bst_exec;
  logic        SYS_CLK = 1'h0, ARST_N = 1'h0, EXEC_START = 1'h0, sk_seen = 1'h0;
  logic [1:0]  EXEC_OP = 2'h3;
  logic [2:0]  EXEC_BIT = 3'h0;
  logic [7:0]  EXEC_ADDR = 8'h00, TABLE_POINTER = 8'h00, DM_RDATA, DM_ADDR, DM_WDATA;
  logic [3:0]  PC_PAGE = 4'h0;
  logic [14:0] PM_RDATA;
  logic [11:0] PM_ADDR;
  logic [6:0]  TABLE_HIGH_BYTE;
  logic        DM_RD_EN, DM_WR_EN, PM_RD_EN, SKIP_NEXT, DUMMY_SLOT, FLAG_WE, BUSY, EXEC_DONE;
  logic [28:0] exp_q[$], res;
  int          bad_count = 0, cmp_count = 0;
  bst_exec dut_u (.SYS_CLK, .ARST_N, .EXEC_START, .EXEC_OP, .EXEC_ADDR, .EXEC_BIT, .TABLE_POINTER, .PC_PAGE,
    .DM_RDATA, .PM_RDATA, .DM_RD_EN, .DM_WR_EN, .DM_ADDR, .DM_WDATA, .PM_RD_EN, .PM_ADDR, .TABLE_HIGH_BYTE,
    .SKIP_NEXT, .DUMMY_SLOT, .FLAG_WE, .BUSY, .EXEC_DONE);
  bst_mem_model mem_u (.clk(SYS_CLK), .dm_rd_en(DM_RD_EN), .dm_addr(DM_ADDR), .pm_rd_en(PM_RD_EN),
    .pm_addr(PM_ADDR), .dm_rdata(DM_RDATA), .pm_rdata(PM_RDATA));
  initial forever #10 SYS_CLK = ~SYS_CLK;
  task automatic check(string name, logic [28:0] seen, logic [28:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Returns in the done cycle so the next call issues back to back
  task automatic run_op(logic [1:0] op, logic [7:0] a, logic [2:0] b, logic [7:0] p, logic [3:0] pg);
    logic [11:0] pa;
    logic [7:0]  d;
    int          n;
    int          w;
    pa = {(op == 2'h2) ? bst_pkg::LAST_PAGE : pg, p};
    d = a ^ 8'hA5;
    w = (op == 2'h0 && d[b] == bst_pkg::SKIP_LEVEL) ? 2 : 1;
    if (op == 2'h0) exp_q.push_back({d[b] == bst_pkg::SKIP_LEVEL, 28'h0});
    else exp_q.push_back({2'h1, pa[7:0], pa[2:0], pa[11:8], pa});
    EXEC_OP = op;
    EXEC_ADDR = a;
    EXEC_BIT = b;
    TABLE_POINTER = p;
    PC_PAGE = pg;
    EXEC_START = 1'h1;
    @(posedge SYS_CLK) #1;
    EXEC_START = 1'h0;
    for (n = 0; n < 8 && EXEC_DONE !== 1'h1; n++) @(posedge SYS_CLK) #1;
    if (EXEC_DONE !== 1'h1) check("done", 29'h0, 29'h1);
    check("cycles", 29'(n), 29'(w));
  endtask : run_op
  always @(negedge SYS_CLK) begin
    if (SKIP_NEXT === 1'h1) sk_seen <= 1'h1;
    if (EXEC_DONE === 1'h1) begin
      check("flag_we", 29'(FLAG_WE), 29'h0);
      res = {sk_seen, DM_WR_EN, DM_WR_EN ? {DM_WDATA, TABLE_HIGH_BYTE, PM_ADDR} : 27'h0};
      check("result", res, exp_q.pop_front());
      sk_seen <= 1'h0;
    end
  end
  // 4000 clock cycles, about twenty times the expected run length
  initial begin
    #(20 * 4000);
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(29895));
    repeat (20) @(posedge SYS_CLK);
    #1 ARST_N = 1'h1;
    @(posedge SYS_CLK) #1;
    for (int b = 0; b < 8; b++) run_op(2'h0, 8'h00, 3'(b), 8'h00, 4'h0);
    run_op(2'h1, 8'hFF, 3'h0, 8'hFF, 4'h7);
    run_op(2'h2, 8'h00, 3'h0, 8'hFF, 4'h3);
    run_op(2'h1, 8'h80, 3'h0, 8'h00, 4'h0);
    $display("test boundaries done");
    repeat (60) run_op(2'($urandom_range(2, 0)), 8'($urandom), 3'($urandom), 8'($urandom), 4'($urandom));
    $display("test random done");
    EXEC_OP = 2'h3;
    EXEC_START = 1'h1;
    @(posedge SYS_CLK) #1;
    EXEC_START = 1'h0;
    @(posedge SYS_CLK) #1;
    check("idle", {BUSY, DM_RD_EN, PM_RD_EN, FLAG_WE}, 29'h0);
    $display("test no-op done");
    repeat (3) @(posedge SYS_CLK);
    stop_test();
  end
endmodule : tb_bst_exec
bind bst_exec bst_exec_asserts chk_u (.SYS_CLK, .ARST_N, .EXEC_START, .DM_RD_EN, .DM_WR_EN, .PM_RD_EN, .SKIP_NEXT,
  .DUMMY_SLOT, .FLAG_WE, .BUSY, .EXEC_DONE, .EXEC_OP, .EXEC_BIT, .EXEC_ADDR, .TABLE_POINTER, .DM_RDATA, .DM_ADDR,
  .DM_WDATA, .PC_PAGE, .PM_RDATA, .PM_ADDR, .TABLE_HIGH_BYTE);
